/* src/sfc_pkg.sv */
package sfc_pkg;
   // opcodes
   localparam logic [7:0] OP_WR_EN = 8'h06;
   localparam logic [7:0] OP_WR_DIS = 8'h04;
   localparam logic [7:0] OP_VOL_EN = 8'h50;
   localparam logic [7:0] OP_RD_SR1 = 8'h05;
   localparam logic [7:0] OP_RD_SR2 = 8'h35;
   localparam logic [7:0] OP_RD_SR3 = 8'h15;
   localparam logic [7:0] OP_WR_SR1 = 8'h01;
   localparam logic [7:0] OP_WR_SR2 = 8'h31;
   localparam logic [7:0] OP_WR_SR3 = 8'h11;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST = 8'h0b;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
   localparam logic [7:0] OP_DUAL_IO = 8'hbb;
   localparam logic [7:0] OP_QUAD_IO = 8'heb;
   localparam logic [7:0] OP_QUAD_WORD = 8'he7;
   localparam logic [7:0] OP_SEC_RD = 8'h48;
   localparam logic [7:0] OP_WRAP = 8'h77;
   // status layout
   localparam int SR_STAT_LO = 7;
   localparam int SR_STAT_HI = 8;
   localparam int SR_QUAD_EN = 9;
   localparam logic [23:0] SR_WR_MASK = 24'h607ffc;
   localparam logic [23:0] SR_RST = 24'h000000;
   localparam logic [2:0] WRAP_RST = 3'h1;
   localparam logic [1:0] CONT_KEEP = 2'h2;
   localparam logic [15:0] SEC3_PAGE = 16'h0030;
   // timing
   localparam int CLK_NS = 20;
   localparam int TW_NS = 10000;
   localparam logic [15:0] TW_CYC = 16'((TW_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [2:0] {
      PH_OPC = 3'b000,
      PH_ADDR = 3'b001,
      PH_DUMMY = 3'b010,
      PH_DOUT = 3'b011,
      PH_DIN = 3'b100,
      PH_END = 3'b101,
      PH_WSR = 3'b110,
      PH_IGN = 3'b111
   } sfc_phase_e;

   typedef struct packed {
      sfc_phase_e ph;
      logic [2:0] win;
      logic [4:0] cnt;
      logic mode;
      logic [3:0] dum;
      logic [2:0] wout;
   } sfc_cfg_s;

   localparam sfc_cfg_s CFG_RST = '{ph:PH_IGN, win:3'd1, cnt:5'd0, mode:1'b0, dum:4'd0,
                                    wout:3'd1};
   localparam sfc_cfg_s CFG_OPC = '{ph:PH_OPC, win:3'd1, cnt:5'd8, mode:1'b0, dum:4'd0,
                                    wout:3'd1};
endpackage

/* src/sfc_flash_front.sv */
`timescale 1ns/1ps
// How it works
// - dual data out: bit 7 on lane 1, bit 6 on lane 0, two per clock
// - quad data out: upper nibble first, bit 7 on lane 3
// - quad io read waits four dummy clocks before data
// - quad io word read waits two dummy clocks; host keeps address bit 0 low
// - third security page decodes at address 0x0030xx
// - wrap bits sit in the seventh nibble, lanes 0 to 2
// - write enable alone in a frame sets the latch
// - write disable, power-up and finished cycles clear the latch
// - status reads return one of three bytes repeatedly, even when busy
// - status write needs latch or volatile enable and keeps fixed bits unchanged
// - status write runs only if frame ends right after eight data bits
// - frame end starts timed cycle; busy flag high, latch cleared at end
// - status write ignored in hardware protected mode
// - volatile enable lets only next status write skip the timed cycle
// - plain read: three address bytes, bytes out, address increments
// - memory reads while busy are rejected; status reads still run
// - fast and dual output reads take one dummy byte
// - quad output read: single lane address, dummy byte, nibbles out
// - dual io read takes address and mode two bits per clock
// - mode bits 10 let next frame skip the opcode
// - quad io reads need the quad enable bit
module sfc_flash_front #(
   parameter int ADDR_W = 24
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe_n,
   output logic [ADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   output logic mem_sec3,
   input wire logic ext_busy,
   input wire logic ext_done,
   output logic write_enable_latch,
   output logic write_in_progress,
   output logic quad_enable
);
   import sfc_pkg::*;

   typedef struct packed {
      logic cs_m;
      logic cs_s;
      logic cs_p;
      logic sck_m;
      logic sck_s;
      logic sck_p;
      logic [3:0] io_m;
      logic [3:0] io_s;
      sfc_cfg_s cfg;
      logic [7:0] opc;
      logic [31:0] sh;
      logic [ADDR_W-1:0] addr;
      logic [7:0] ob;
      logic [2:0] slot;
      logic [3:0] io_o;
      logic [3:0] oe_n;
      logic lat;
      logic [23:0] sr;
      logic vol;
      logic [7:0] cont;
      logic cyc;
      logic [15:0] tw;
      logic [2:0] wrap;
      logic sec;
   } sfc_st_s;

   localparam sfc_st_s ST_RST = '{cs_m:1'b1, cs_s:1'b1, cs_p:1'b1, oe_n:4'hf, wrap:WRAP_RST,
                                  cfg:CFG_RST, sr:SR_RST, default:'0};

   function automatic sfc_cfg_s setup(input logic [7:0] op, input logic busy, input logic qen,
                                      input logic wok);
      sfc_cfg_s c;
      c = '{ph:PH_IGN, win:3'd1, cnt:5'd24, mode:1'b0, dum:4'd0, wout:3'd1};
      case (op)
         OP_WR_EN, OP_WR_DIS, OP_VOL_EN: c.ph = PH_END;
         OP_RD_SR1, OP_RD_SR2, OP_RD_SR3: c.ph = PH_DOUT;
         OP_WR_SR1, OP_WR_SR2, OP_WR_SR3: begin
            c.ph = wok ? PH_DIN : PH_IGN;
            c.cnt = 5'd8;
         end
         OP_WRAP: begin
            c.ph = PH_ADDR;
            c.win = 3'd4;
            c.cnt = 5'd8;
         end
         OP_READ: c.ph = PH_ADDR;
         OP_FAST, OP_SEC_RD: begin
            c.ph = PH_ADDR;
            c.dum = 4'd8;
         end
         OP_DUAL_OUT: begin
            c.ph = PH_ADDR;
            c.dum = 4'd8;
            c.wout = 3'd2;
         end
         OP_QUAD_OUT: begin
            c.ph = PH_ADDR;
            c.dum = 4'd8;
            c.wout = 3'd4;
         end
         OP_DUAL_IO: begin
            c.ph = PH_ADDR;
            c.win = 3'd2;
            c.cnt = 5'd16;
            c.mode = 1'b1;
            c.wout = 3'd2;
         end
         OP_QUAD_IO, OP_QUAD_WORD: begin
            c.ph = PH_ADDR;
            c.win = 3'd4;
            c.cnt = 5'd8;
            c.mode = 1'b1;
            c.dum = (op == OP_QUAD_IO) ? 4'd4 : 4'd2;
            c.wout = 3'd4;
         end
         default: c.ph = PH_IGN;
      endcase
      if (busy && c.ph == PH_ADDR && op != OP_WRAP) c.ph = PH_IGN;
      if ((op == OP_QUAD_IO || op == OP_QUAD_WORD) && !qen) c.ph = PH_IGN;
      return c;
   endfunction

   // lane 0 first bit for single, {io1,io0} for dual, {io3..io0} for quad
   function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [3:0] io,
                                            input logic [2:0] w);
      case (w)
         3'd4: shift_in = {sh[27:0], io};
         3'd2: shift_in = {sh[29:0], io[1:0]};
         default: shift_in = {sh[30:0], io[0]};
      endcase
   endfunction

   function automatic logic [3:0] drive(input logic [7:0] b, input logic [2:0] w);
      case (w)
         3'd4: drive = b[7:4];
         3'd2: drive = {2'b00, b[7:6]};
         default: drive = {2'b00, b[7], 1'b0};
      endcase
   endfunction

   function automatic logic [3:0] lanes_oe_n(input logic [2:0] w);
      case (w)
         3'd4: lanes_oe_n = 4'h0;
         3'd2: lanes_oe_n = 4'hc;
         default: lanes_oe_n = 4'hd;
      endcase
   endfunction

   function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                   input logic [2:0] wr, input logic wrap_ok);
      logic [5:0] m;
      logic [5:0] inc;
      m = 6'((7'd8 << wr[2:1]) - 7'd1);
      inc = a[5:0] + 6'd1;
      if (wrap_ok && !wr[0]) next_addr = {a[ADDR_W-1:6], (a[5:0] & ~m) | (inc & m)};
      else next_addr = a + 1'b1;
   endfunction

   logic [1:0] rst_q;
   logic rst_i_n;
   sfc_st_s s_r;
   sfc_st_s s_nxt;
   logic rise;
   logic fall;
   logic cs_rise;
   logic cs_fall;
   logic hwp;
   logic busy;
   logic [23:0] stat;
   logic [31:0] sh_new;
   logic [7:0] src;
   logic [7:0] byte_out;
   logic [3:0] hi_nib;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) rst_q <= 2'b00;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_i_n = rst_q[1];

   assign rise = s_r.sck_s & ~s_r.sck_p & ~s_r.cs_s;
   assign fall = ~s_r.sck_s & s_r.sck_p & ~s_r.cs_s;
   assign cs_rise = s_r.cs_s & ~s_r.cs_p;
   assign cs_fall = ~s_r.cs_s & s_r.cs_p;
   // io2 doubles as the write protect pin
   assign hwp = ~s_r.sr[SR_STAT_HI] & s_r.sr[SR_STAT_LO] & ~s_r.io_s[2];
   assign busy = s_r.cyc | ext_busy;
   assign stat = {s_r.sr[23:2], s_r.lat, s_r.cyc};
   assign sh_new = shift_in(s_r.sh, s_r.io_s, s_r.cfg.win);
   assign hi_nib = mem_rdata[7:4];

   always_comb begin
      case (s_r.opc)
         OP_RD_SR1: src = stat[7:0];
         OP_RD_SR2: src = stat[15:8];
         OP_RD_SR3: src = stat[23:16];
         default: src = mem_rdata;
      endcase
      byte_out = (s_r.slot == 3'd0) ? src : s_r.ob;
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.cs_m = cs_n;
      s_nxt.cs_s = s_r.cs_m;
      s_nxt.cs_p = s_r.cs_s;
      s_nxt.sck_m = sclk;
      s_nxt.sck_s = s_r.sck_m;
      s_nxt.sck_p = s_r.sck_s;
      s_nxt.io_m = io_in;
      s_nxt.io_s = s_r.io_m;
      s_nxt.sec = (s_r.opc == OP_SEC_RD) && (s_r.addr[23:8] == SEC3_PAGE);
      if (s_r.cyc) begin
         s_nxt.tw = s_r.tw - 16'd1;
         if (s_r.tw == 16'd1) begin
            s_nxt.cyc = 1'b0;
            s_nxt.lat = 1'b0;
         end
      end
      if (ext_done) s_nxt.lat = 1'b0;
      if (cs_rise) begin
         s_nxt.oe_n = 4'hf;
         s_nxt.cfg.ph = PH_IGN;
         if (!(s_r.cfg.ph == PH_END && s_r.opc == OP_VOL_EN)) s_nxt.vol = 1'b0;
         case (s_r.cfg.ph)
            PH_END: begin
               case (s_r.opc)
                  OP_WR_EN: s_nxt.lat = 1'b1;
                  OP_WR_DIS: s_nxt.lat = 1'b0;
                  OP_VOL_EN: s_nxt.vol = 1'b1;
                  default: ;
               endcase
            end
            PH_WSR: begin
               if (!hwp) begin
                  case (s_r.opc)
                     OP_WR_SR1: s_nxt.sr[7:0] = (s_r.sr[7:0] & ~SR_WR_MASK[7:0]) |
                                                (s_r.sh[7:0] & SR_WR_MASK[7:0]);
                     OP_WR_SR2: s_nxt.sr[15:8] = (s_r.sr[15:8] & ~SR_WR_MASK[15:8]) |
                                                 (s_r.sh[7:0] & SR_WR_MASK[15:8]);
                     default: s_nxt.sr[23:16] = (s_r.sr[23:16] & ~SR_WR_MASK[23:16]) |
                                                (s_r.sh[7:0] & SR_WR_MASK[23:16]);
                  endcase
                  if (!s_r.vol) begin
                     s_nxt.cyc = 1'b1;
                     s_nxt.tw = TW_CYC;
                  end
               end
            end
            default: ;
         endcase
      end else if (cs_fall) begin
         s_nxt.sh = 32'h0;
         s_nxt.slot = 3'd0;
         if (s_r.cont != 8'h00) begin
            s_nxt.opc = s_r.cont;
            s_nxt.cfg = setup(s_r.cont, busy, s_r.sr[SR_QUAD_EN], 1'b0);
         end else begin
            s_nxt.cfg = CFG_OPC;
         end
      end else if (rise) begin
         case (s_r.cfg.ph)
            PH_OPC, PH_ADDR, PH_DIN: begin
               s_nxt.sh = sh_new;
               s_nxt.cfg.cnt = s_r.cfg.cnt - 5'd1;
               if (s_r.cfg.cnt == 5'd1) begin
                  case (s_r.cfg.ph)
                     PH_OPC: begin
                        s_nxt.opc = sh_new[7:0];
                        s_nxt.cfg = setup(sh_new[7:0], busy, s_r.sr[SR_QUAD_EN],
                                          (s_r.lat | s_r.vol) & ~busy);
                     end
                     PH_ADDR: begin
                        if (s_r.opc == OP_WRAP) begin
                           s_nxt.wrap = sh_new[6:4];
                           s_nxt.cfg.ph = PH_IGN;
                        end else begin
                           s_nxt.addr = s_r.cfg.mode ? sh_new[31:8] : sh_new[23:0];
                           if (s_r.cfg.mode)
                              s_nxt.cont = (sh_new[5:4] == CONT_KEEP) ? s_r.opc : 8'h00;
                           s_nxt.cfg.cnt = 5'(s_r.cfg.dum);
                           s_nxt.cfg.ph = (s_r.cfg.dum != 4'd0) ? PH_DUMMY : PH_DOUT;
                        end
                     end
                     default: s_nxt.cfg.ph = PH_WSR;
                  endcase
               end
            end
            PH_DUMMY: begin
               s_nxt.cfg.cnt = s_r.cfg.cnt - 5'd1;
               if (s_r.cfg.cnt == 5'd1) s_nxt.cfg.ph = PH_DOUT;
            end
            PH_END, PH_WSR: s_nxt.cfg.ph = PH_IGN;
            default: ;
         endcase
      end else if (fall && s_r.cfg.ph == PH_DOUT) begin
         s_nxt.io_o = drive(byte_out, s_r.cfg.wout);
         s_nxt.oe_n = lanes_oe_n(s_r.cfg.wout);
         s_nxt.ob = byte_out << s_r.cfg.wout;
         s_nxt.slot = (s_r.slot == 3'(8 / s_r.cfg.wout - 1)) ? 3'd0 : s_r.slot + 3'd1;
         if (s_r.slot == 3'd0 && src == mem_rdata && s_r.opc != OP_RD_SR1 &&
             s_r.opc != OP_RD_SR2 && s_r.opc != OP_RD_SR3)
            s_nxt.addr = next_addr(s_r.addr, s_r.wrap,
                                   s_r.opc == OP_QUAD_IO || s_r.opc == OP_QUAD_WORD);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_i_n) begin
      if (!rst_i_n) s_r <= ST_RST;
      else s_r <= s_nxt;
   end

   assign io_out = s_r.io_o;
   assign io_oe_n = s_r.oe_n;
   assign mem_addr = s_r.addr;
   assign mem_sec3 = s_r.sec;
   assign write_enable_latch = s_r.lat;
   assign write_in_progress = s_r.cyc;
   assign quad_enable = s_r.sr[SR_QUAD_EN];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_i_n);

   sequence cmd_end(logic [7:0] op);
      cs_rise && s_r.cfg.ph == PH_END && s_r.opc == op;
   endsequence
   sequence opc_done;
      rise && s_r.cfg.ph == PH_OPC && s_r.cfg.cnt == 5'd1;
   endsequence

   a_latch_set_cmd: assert property (cmd_end(OP_WR_EN) |=> write_enable_latch)
      else $error("latch not set by write enable");
   a_latch_clr_cmd: assert property (cmd_end(OP_WR_DIS) ##0 !ext_done |=> !write_enable_latch)
      else $error("latch not cleared by write disable");
   a_cycle_holds: assert property ($rose(write_in_progress) |-> write_in_progress [*8])
      else $error("busy flag dropped early");
   a_latch_at_end: assert property ($fell(write_in_progress) && !$past(cs_rise)
                                    |-> !write_enable_latch)
      else $error("latch survived end of cycle");
   a_read_busy: assert property (opc_done ##0 (busy && sh_new[7:0] == OP_READ)
                                 |=> s_r.cfg.ph == PH_IGN)
      else $error("read accepted while busy");
   a_quad_gate: assert property (opc_done ##0 (sh_new[7:0] == OP_QUAD_IO &&
                                 !s_r.sr[SR_QUAD_EN]) |=> s_r.cfg.ph == PH_IGN)
      else $error("quad io read without quad enable");
   a_fixed_bits: assert property (cs_rise |=> (s_r.sr & ~SR_WR_MASK) ==
                                  ($past(s_r.sr) & ~SR_WR_MASK))
      else $error("fixed status bits changed");
   a_hw_protect: assert property (cs_rise && s_r.cfg.ph == PH_WSR && hwp
                                  |=> $stable(s_r.sr) && !write_in_progress)
      else $error("status write in protected mode");
   a_quad_nibble: assert property (fall && s_r.cfg.ph == PH_DOUT && s_r.cfg.wout == 3'd4 &&
                                   s_r.slot == 3'd0 && s_r.opc == OP_QUAD_IO
                                   |=> io_out == $past(hi_nib) && io_oe_n == 4'h0)
      else $error("wrong upper nibble");
   a_release_oe: assert property (cs_rise |=> io_oe_n == 4'hf)
      else $error("lanes still driven after frame");
endmodule // sfc_flash_front

/* tb/sfc_host_model.sv */
`timescale 1ns/1ps
module sfc_host_model (
   input wire logic clk_sys,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe_n,
   output logic cs_n,
   output logic sclk,
   output logic [3:0] io_in
);
   logic [3:0] drv_val;
   logic [3:0] drv_en;
   logic [3:0] float_r;
   logic [3:0] oe_acc;
   logic wp_level;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      drv_val = 4'h0;
      drv_en = 4'h5;
      float_r = 4'h0;
      wp_level = 1'b1;
      oe_acc = 4'hf;
   end
   // released lanes toggle so a stale value never reads as valid
   always @(posedge clk_sys) begin
      float_r <= ~float_r;
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         io_in[i] = !io_oe_n[i] ? io_out[i] : (drv_en[i] ? drv_val[i] : float_r[i]);
      end
   end
   task automatic start();
      @(negedge clk_sys);
      cs_n = 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask
   // msb first, lane groups {io1,io0} and {io3..io0}
   task automatic send(input logic [31:0] v, input int lanes, input int nbits);
      logic [3:0] nib;
      for (int b = nbits; b > 0; b -= lanes) begin
         nib = 4'(v >> (b - lanes));
         sclk = 1'b0;
         drv_en = (lanes == 4) ? 4'hf : ((lanes == 2) ? 4'h7 : 4'h5);
         drv_val = (lanes == 4) ? nib : {1'b0, wp_level, (lanes == 2) ? nib[1:0] : {1'b0, nib[0]}};
         repeat (4) @(negedge clk_sys);
         sclk = 1'b1;
         repeat (4) @(negedge clk_sys);
      end
   endtask
   // sample late in the high phase to cover the sampling latency
   task automatic recv(input int lanes, input int nbits, output logic [31:0] v);
      v = 32'h0;
      oe_acc = 4'hf;
      drv_en = (lanes == 1) ? 4'h5 : ((lanes == 2) ? 4'h4 : 4'h0);
      for (int b = 0; b < nbits; b += lanes) begin
         sclk = 1'b0;
         repeat (4) @(negedge clk_sys);
         sclk = 1'b1;
         repeat (3) @(negedge clk_sys);
         v = (v << lanes) | (lanes == 4 ? 32'(io_in) : (lanes == 2 ? 32'(io_in[1:0]) : 32'(io_in[1])));
         oe_acc &= io_oe_n;
         @(negedge clk_sys);
      end
   endtask
   // frame closes right after the last bit, no extra rising edge
   task automatic stop();
      sclk = 1'b0;
      repeat (4) @(negedge clk_sys);
      cs_n = 1'b1;
      drv_en = 4'h5;
      repeat (8) @(negedge clk_sys);
   endtask
endmodule // sfc_host_model

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import sfc_pkg::*;
   typedef struct {
      logic [7:0] op;
      int al;
      int ab;
      int db;
      int dl;
      logic [23:0] a;
      logic sec;
   } sfc_row_s;
   logic clk_sys, rst_n, cs_n, sclk, mem_sec3, ext_busy, ext_done, sec;
   logic [3:0] io_in, io_out, io_oe_n;
   logic [23:0] mem_addr;
   logic [7:0] mem_rdata;
   logic write_enable_latch, write_in_progress, quad_enable;
   logic [31:0] v, e;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   sfc_row_s rows [8] = '{
      '{OP_READ, 1, 24, 0, 1, 24'h000010, 1'b0},
      '{OP_FAST, 1, 24, 8, 1, 24'h0000ff, 1'b0},
      '{OP_DUAL_OUT, 1, 24, 8, 2, 24'h012345, 1'b0},
      '{OP_QUAD_OUT, 1, 24, 8, 4, 24'h00abcd, 1'b0},
      '{OP_DUAL_IO, 2, 32, 0, 2, 24'h001230, 1'b0},
      '{OP_QUAD_IO, 4, 32, 16, 4, 24'h0200f0, 1'b0},
      '{OP_QUAD_WORD, 4, 32, 8, 4, 24'h000402, 1'b0},
      '{OP_SEC_RD, 1, 24, 8, 1, 24'h003007, 1'b1}
   };
   function automatic logic [7:0] mem_fn(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   assign mem_rdata = mem_fn(mem_addr);
   sfc_flash_front dut (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
      .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .mem_sec3(mem_sec3), .ext_busy(ext_busy), .ext_done(ext_done),
      .write_enable_latch(write_enable_latch), .write_in_progress(write_in_progress),
      .quad_enable(quad_enable));
   sfc_host_model h (.clk_sys(clk_sys), .io_out(io_out), .io_oe_n(io_oe_n), .cs_n(cs_n),
      .sclk(sclk), .io_in(io_in));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic complete_run();
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         complete_run();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one frame: opcode, address, dummy, then nb data bits
   task automatic fr(input int ob, input logic [7:0] op, input logic [31:0] a, input int al,
      input int ab, input int db, input int dl, input int nb);
      h.start();
      h.send(32'(op), 1, ob);
      h.send(a, al, ab);
      h.send(32'h0, al == 4 ? 4 : 1, db);
      h.recv(dl, nb, v);
      sec = mem_sec3;
      h.stop();
   endtask
   task automatic wait_cycle();
      int n = 0;
      while (write_in_progress !== 1'b0 && n < 700) begin
         @(negedge clk_sys);
         n++;
      end
      chk("cycle done", 32'(write_in_progress), 32'h0);
   endtask
   initial begin
      rst_n = 1'b0;
      ext_busy = 1'b0;
      ext_done = 1'b0;
      repeat (12) @(negedge clk_sys);
      chk("reset oe", 32'(io_oe_n), 32'hf);
      chk("reset latch", 32'(write_enable_latch), 32'h0);
      rst_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      fr(8, OP_VOL_EN, 32'h0, 1, 0, 0, 1, 0);
      fr(8, OP_WR_SR2, 32'h82, 1, 8, 0, 1, 0);
      chk("quad enable", 32'(quad_enable), 32'h1);
      chk("volatile cycle", 32'(write_in_progress), 32'h0);
      foreach (rows[i]) begin
         e = rows[i].ab == 32 ? {rows[i].a, 8'h00} : 32'(rows[i].a);
         fr(8, rows[i].op, e, rows[i].al, rows[i].ab, rows[i].db, rows[i].dl, 16);
         e = {16'h0, mem_fn(rows[i].a), mem_fn(rows[i].a + 24'h1)};
         chk("row data", v, e);
         chk("row sec3", 32'(sec), 32'(rows[i].sec));
      end
      fr(8, OP_WR_EN, 32'h0, 1, 0, 0, 1, 0);
      chk("latch set", 32'(write_enable_latch), 32'h1);
      fr(8, OP_WR_SR3, 32'hff, 1, 8, 0, 1, 0);
      chk("cycle busy", 32'(write_in_progress), 32'h1);
      fr(8, OP_RD_SR1, 32'h0, 1, 0, 0, 1, 16);
      chk("status busy", v, 32'h0303);
      wait_cycle();
      chk("latch end", 32'(write_enable_latch), 32'h0);
      fr(8, OP_RD_SR3, 32'h0, 1, 0, 0, 1, 16);
      chk("status fixed bits", v, 32'h6060);
      fr(8, OP_WR_SR1, 32'h1c, 1, 8, 0, 1, 0);
      chk("write no latch", 32'(write_in_progress), 32'h0);
      fr(8, OP_WR_EN, 32'h0, 1, 0, 0, 1, 0);
      fr(8, OP_WR_SR1, 32'h38, 1, 9, 0, 1, 0);
      chk("nine bit write", 32'(write_in_progress), 32'h0);
      fr(8, OP_WR_DIS, 32'h0, 1, 0, 0, 1, 0);
      chk("latch off", 32'(write_enable_latch), 32'h0);
      fr(8, OP_RD_SR1, 32'h0, 1, 0, 0, 1, 16);
      chk("status kept", v, 32'h0);
      fr(8, OP_WR_EN, 32'h0, 1, 0, 0, 1, 0);
      ext_done = 1'b1;
      @(negedge clk_sys);
      ext_done = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("done clears", 32'(write_enable_latch), 32'h0);
      ext_busy = 1'b1;
      fr(8, OP_READ, 32'h10, 1, 24, 0, 1, 8);
      chk("busy reject", 32'(h.oe_acc), 32'hf);
      ext_busy = 1'b0;
      fr(8, OP_VOL_EN, 32'h0, 1, 0, 0, 1, 0);
      fr(8, OP_WR_SR1, 32'h9c, 1, 8, 0, 1, 0);
      h.wp_level = 1'b0;
      fr(8, OP_VOL_EN, 32'h0, 1, 0, 0, 1, 0);
      fr(8, OP_WR_SR1, 32'h00, 1, 8, 0, 1, 0);
      h.wp_level = 1'b1;
      fr(8, OP_RD_SR1, 32'h0, 1, 0, 0, 1, 16);
      chk("hw protect", v, 32'h9c9c);
      fr(8, OP_DUAL_IO, {24'h000500, 8'h20}, 2, 32, 0, 2, 16);
      chk("cont first", v, {16'h0, mem_fn(24'h000500), mem_fn(24'h000501)});
      fr(0, 8'h00, {24'h000600, 8'h00}, 2, 32, 0, 2, 16);
      chk("cont skip", v, {16'h0, mem_fn(24'h000600), mem_fn(24'h000601)});
      fr(8, OP_RD_SR2, 32'h0, 1, 0, 0, 1, 16);
      chk("cont off", v, 32'h0202);
      fr(8, OP_WRAP, 32'hffffff0f, 4, 32, 0, 1, 0);
      fr(8, OP_QUAD_IO, {24'h000106, 8'h00}, 4, 32, 16, 4, 24);
      e = {8'h0, mem_fn(24'h000106), mem_fn(24'h000107), mem_fn(24'h000100)};
      chk("wrap", v, e);
      rst_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk("second reset quad", 32'(quad_enable), 32'h0);
      chk("second reset addr", 32'(mem_addr), 32'h0);
      chk("second reset latch", 32'(write_enable_latch), 32'h0);
      rst_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      fr(8, OP_QUAD_IO, {24'h000100, 8'h00}, 4, 32, 16, 4, 8);
      chk("quad gate", 32'(h.oe_acc), 32'hf);
      complete_run();
   end
endmodule // testbench
